//--- hdl/vk_keyer.sv
// pixel keyer: cut to key control, background attenuation, fill shaping
`timescale 1ns/1ps
`default_nettype none
module vk_keyer
   import vk_pkg::*;
(
   // clock and reset
   input  wire  logic                 clk_i,
   input  wire  logic                 rst_i,
   // wishbone classic slave
   input  wire  logic                 wb_cyc_i,
   input  wire  logic                 wb_stb_i,
   input  wire  logic                 wb_we_i,
   input  wire  logic [7:0]           wb_adr_i,
   input  wire  logic [3:0]           wb_sel_i,
   input  wire  logic [31:0]          wb_dat_i,
   output logic       [31:0]          wb_dat_o,
   output logic                       wb_ack_o,
   // video in
   input  wire  logic                 pix_vld_i,
   input  wire  logic [vk_pkg::PW-1:0] bg_i,
   input  wire  logic [vk_pkg::PW-1:0] cut_i,
   input  wire  logic [vk_pkg::PW-1:0] fill_i,
   input  wire  logic [vk_pkg::PW-1:0] pat_i,
   // video out
   output logic [vk_pkg::PW-1:0]      comp_o,
   output logic                       comp_vld_o,
   output logic [vk_pkg::KW-1:0]      key_o
);
   import vk_pkg::*;

   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      logic                   ack;
      logic [31:0]            rdat;
      logic [CW-1:0]          ctrl;
      logic signed [TW-1:0]   clip;
      logic [GW-1:0]          gain;
      logic [TW-1:0]          span;
      logic [TW-1:0]          half;
      logic signed [TW-1:0]   upper;
      logic signed [TW-1:0]   lower;
      logic [PW-1:0]          matte;
      logic [QW-1:0]          recip;
      logic [TW:0]            rem;
      logic [QW-1:0]          quo;
      logic [4:0]             cnt;
      vk_st_t                 st;
      logic                   v1;
      logic [KW-1:0]          k1;
      logic [PW-1:0]          bg1;
      logic [PW-1:0]          fill1;
      logic                   add1;
      logic                   v2;
      logic [PW-1:0]          out;
      logic [KW-1:0]          key;
   } vk_state_t;

   vk_state_t s_q;
   vk_state_t s_d;

   function automatic logic [31:0] vk_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  sel);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++)
      begin
         if (sel[b])
         begin
            r[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return r;
   endfunction : vk_merge

   function automatic logic [31:0] vk_sx(input logic [TW-1:0] v);
      return {{(32-TW){v[TW-1]}}, v};
   endfunction : vk_sx

   // span in code units back to a gain percentage, rounded
   function automatic logic [GW-1:0] vk_pct(input logic [TW-1:0] sp);
      logic [28:0] p;
      p = 29'(sp * S2G_MUL) + S2G_RND;
      p = p >> S2G_SH;
      return (p > 29'(GAIN_MAX)) ? GAIN_MAX : p[GW-1:0];
   endfunction : vk_pct

   // ************************************************************
   // next state
   // ************************************************************
   logic                   req;
   logic [31:0]            wv;
   logic [31:0]            rv;
   logic signed [TW-1:0]   nt;
   logic [21:0]            sp22;
   logic [TW-1:0]          sp;
   logic [TW:0]            r2;
   logic                   go_div;
   logic [PW-1:0]          cut_v;
   logic [PW-1:0]          fill_v;
   logic signed [TW-1:0]   cs;
   logic signed [TW-1:0]   diff;
   logic [38:0]            prod;
   logic [KW-1:0]          kc;
   logic [2:0]             kt;
   logic [21:0]            acc;
   logic [11:0]            sum;

   always_comb
   begin
      s_d = s_q;
      req = wb_cyc_i & wb_stb_i & ~s_q.ack;
      wv = 32'h0000_0000;
      rv = 32'h0000_0000;
      nt = '0;
      sp22 = '0;
      sp = '0;
      r2 = '0;
      go_div = 1'b0;
      kt = s_q.ctrl[CT_TYPE_LSB +: 3];

      // ---- bus: one wait state, ack drops after one cycle
      s_d.ack = req;
      case (wb_adr_i)
         ADR_CTRL  : rv = {{(32-CW){1'b0}}, s_q.ctrl};
         ADR_CLIP  : rv = vk_sx(s_q.clip);
         ADR_GAIN  : rv = {{(32-GW){1'b0}}, s_q.gain};
         ADR_UPPER : rv = vk_sx(s_q.upper);
         ADR_LOWER : rv = vk_sx(s_q.lower);
         ADR_MATTE : rv = {{(32-PW){1'b0}}, s_q.matte};
         ADR_STAT  : rv = {15'h0000, s_q.st == VK_DIV, 5'h00, s_q.key};
         default   : rv = 32'h0000_0000;
      endcase
      s_d.rdat = req ? rv : 32'h0000_0000;
      wv = vk_merge(rv, wb_dat_i, wb_sel_i);

      if (req && wb_we_i)
      begin
         case (wb_adr_i)
            ADR_CTRL  : s_d.ctrl = wv[CW-1:0];
            ADR_MATTE : s_d.matte = wv[PW-1:0];
            ADR_CLIP  :
            begin
               // clip alone moves both thresholds, gain kept
               nt = signed'(wv[TW-1:0]);
               s_d.clip = nt;
               s_d.upper = nt + signed'(s_q.half);
               s_d.lower = nt - signed'(s_q.half);
            end
            ADR_GAIN  :
            begin
               sp22 = 22'(wv[GW-1:0] * G2S_MUL);
               sp = TW'(sp22 >> G2S_SH);
               s_d.gain = wv[GW-1:0];
               s_d.span = sp;
               s_d.half = sp >> 1;
               s_d.upper = s_q.clip + signed'(sp >> 1);
               s_d.lower = s_q.clip - signed'(sp >> 1);
               go_div = 1'b1;
            end
            ADR_UPPER :
            begin
               // never cross below the lower threshold
               nt = signed'(wv[TW-1:0]);
               if (nt < s_q.lower)
               begin
                  nt = s_q.lower;
               end
               sp = TW'(nt - s_q.lower);
               s_d.upper = nt;
               s_d.span = sp;
               s_d.half = sp >> 1;
               s_d.clip = TW'((14'(nt) + 14'(s_q.lower)) >>> 1);
               s_d.gain = vk_pct(sp);
               go_div = 1'b1;
            end
            ADR_LOWER :
            begin
               nt = signed'(wv[TW-1:0]);
               if (nt > s_q.upper)
               begin
                  nt = s_q.upper;
               end
               sp = TW'(s_q.upper - nt);
               s_d.lower = nt;
               s_d.span = sp;
               s_d.half = sp >> 1;
               s_d.clip = TW'((14'(nt) + 14'(s_q.upper)) >>> 1);
               s_d.gain = vk_pct(sp);
               go_div = 1'b1;
            end
            default   : s_d.ctrl = s_q.ctrl;
         endcase
      end

      // ---- serial divider: recip = full scale << 16 / span
      // slow but small; the old slope stays in use until it ends
      case (s_q.st)
         VK_IDLE :
         begin
            s_d.st = VK_IDLE;
         end
         VK_DIV :
         begin
            r2 = {s_q.rem[TW-1:0], s_q.quo[QW-1]};
            s_d.quo = {s_q.quo[QW-2:0], 1'b0};
            if (r2 >= {1'b0, s_q.span})
            begin
               r2 = r2 - {1'b0, s_q.span};
               s_d.quo[0] = 1'b1;
            end
            s_d.rem = r2;
            s_d.cnt = s_q.cnt + 5'd1;
            if (s_q.cnt == 5'(QW-1))
            begin
               s_d.recip = s_d.quo;
               s_d.st = VK_IDLE;
            end
         end
         default :
         begin
            s_d.st = VK_IDLE;
         end
      endcase
      if (go_div && sp != '0)
      begin
         s_d.st = VK_DIV;
         s_d.rem = '0;
         s_d.quo = DIV_NUM;
         s_d.cnt = 5'd0;
      end

      // ---- stage 1: source selection and key control
      fill_v = s_q.ctrl[CT_MATTE_BIT] ? s_q.matte : fill_i;
      if (s_q.ctrl[CT_SELF_BIT])
      begin
         cut_v = fill_i;
      end
      else if (kt == KT_PAT)
      begin
         cut_v = pat_i;
      end
      else
      begin
         cut_v = cut_i;
      end
      cs = signed'({{(TW-PW){1'b0}}, cut_v});
      diff = cs - s_q.lower;
      // full width: with a far negative lower threshold diff passes 4095
      prod = 39'(diff[TW-1:0] * s_q.recip) >> KC_SH;
      if (s_q.span == '0)
      begin
         kc = (cs >= s_q.clip) ? KC_FULL : '0;
      end
      else if (cs <= s_q.lower)
      begin
         kc = '0;
      end
      else if (cs >= s_q.upper || prod >= 39'(KC_FULL))
      begin
         kc = KC_FULL;
      end
      else
      begin
         kc = prod[KW-1:0];
      end
      s_d.v1 = pix_vld_i;
      if (pix_vld_i)
      begin
         s_d.k1 = kc;
         s_d.bg1 = bg_i;
         s_d.fill1 = fill_v;
         s_d.add1 = (kt == KT_ADD);
      end

      // ---- stage 2: composite with the same key value
      acc = 22'(s_q.bg1 * (KC_FULL - s_q.k1));
      if (s_q.add1)
      begin
         sum = 12'(acc >> MIX_SH) + 12'(s_q.fill1);
      end
      else
      begin
         acc = acc + 22'(s_q.fill1 * s_q.k1);
         sum = 12'(acc >> MIX_SH);
      end
      s_d.v2 = s_q.v1;
      if (s_q.v1)
      begin
         s_d.out = (sum > 12'(PIX_MAX)) ? PIX_MAX : sum[PW-1:0];
         s_d.key = s_q.k1;
      end
   end

   // ************************************************************
   // registers
   // ************************************************************
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s_q <= '0;
         s_q.ctrl <= CTRL_RST;
         s_q.clip <= CLIP_RST;
         s_q.gain <= GAIN_RST;
         s_q.span <= SPAN_RST;
         s_q.half <= HALF_RST;
         s_q.upper <= CLIP_RST + signed'(HALF_RST);
         s_q.lower <= CLIP_RST - signed'(HALF_RST);
         s_q.matte <= MATTE_RST;
         s_q.recip <= RECIP_RST;
         s_q.st <= VK_IDLE;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign wb_ack_o = s_q.ack;
   assign wb_dat_o = s_q.rdat;
   assign comp_o = s_q.out;
   assign comp_vld_o = s_q.v2;
   assign key_o = s_q.key;
endmodule : vk_keyer
`default_nettype wire

//--- include/vk_pkg.sv
// constants and state types for the video keyer with clip/gain control
// Summary of operation
// - composite from background, key cut, key fill
// - fill source: incoming video or matte value
// - self key: one stream gives cut and fill
// - key control from cut alone removes background
// - additive: fill added unmultiplied after attenuation
// - linear/luminance: fill multiplied by key control
// - fill shaped with the background's key value
// - high keeps fill, low keeps background, blend
// - clip moves threshold, gain left unchanged
// - gain 50% ramps over half range
// - gain 100% ramps over full range
// - gain 0% switches hard at clip
// - gain above unity accepted, softer ramp
// - at/above upper opaque, at/below lower transparent
// - upper = clip+gain/2, lower = clip-gain/2
// - each threshold moves without moving other
// - any change recomputes the other pair
// - key types and self/split arrangements selectable
package vk_pkg;
   // ************************************************************
   // widths
   // ************************************************************
   localparam int PW = 10;
   localparam int KW = 11;
   localparam int TW = 13;
   localparam int GW = 8;
   localparam int QW = 27;
   localparam int CW = 6;
   localparam logic [KW-1:0] KC_FULL = 11'h400;
   localparam logic [PW-1:0] PIX_MAX = 10'h3FF;
   localparam logic [QW-1:0] DIV_NUM = 27'h400_0000;
   localparam int KC_SH = 16;
   localparam int MIX_SH = 10;
   // percent to span: span = pct * 1023 / 100
   localparam logic [13:0] G2S_MUL = 14'h28EC;
   localparam int G2S_SH = 10;
   localparam logic [15:0] S2G_MUL = 16'h1906;
   localparam logic [28:0] S2G_RND = 29'h0000_8000;
   localparam int S2G_SH = 16;
   localparam logic [GW-1:0] GAIN_MAX = 8'hFF;
   // ************************************************************
   // register map (byte addresses)
   // ************************************************************
   localparam logic [7:0] ADR_CTRL  = 8'h00;
   localparam logic [7:0] ADR_CLIP  = 8'h04;
   localparam logic [7:0] ADR_GAIN  = 8'h08;
   localparam logic [7:0] ADR_UPPER = 8'h0C;
   localparam logic [7:0] ADR_LOWER = 8'h10;
   localparam logic [7:0] ADR_MATTE = 8'h14;
   localparam logic [7:0] ADR_STAT  = 8'h18;
   localparam int CT_TYPE_LSB = 0;
   localparam int CT_MODE_BIT = 3;
   localparam int CT_MATTE_BIT = 4;
   localparam int CT_SELF_BIT = 5;
   localparam int ST_BUSY_BIT = 16;
   localparam logic [2:0] KT_ADD  = 3'h0;
   localparam logic [2:0] KT_LUM  = 3'h1;
   localparam logic [2:0] KT_LIN  = 3'h2;
   localparam logic [2:0] KT_CHR  = 3'h3;
   localparam logic [2:0] KT_PAT  = 3'h4;
   localparam logic [CW-1:0] CTRL_RST = 6'h01;
   localparam logic signed [TW-1:0] CLIP_RST = 13'h0200;
   localparam logic [GW-1:0] GAIN_RST = 8'h64;
   localparam logic [TW-1:0] SPAN_RST = 13'h03FF;
   localparam logic [TW-1:0] HALF_RST = 13'h01FF;
   // floor(DIV_NUM / SPAN_RST), the slope the divider would give for span 1023
   localparam logic [QW-1:0] RECIP_RST = 27'h001_0040;
   localparam logic [PW-1:0] MATTE_RST = 10'h000;
   typedef enum logic {VK_IDLE, VK_DIV} vk_st_t;
endpackage : vk_pkg

//--- verif/vk_monitor.sv
// port assertions for the keyer
`timescale 1ns/1ps
`default_nettype none
module vk_monitor
   import vk_pkg::*;
(
   // bus
   input wire logic                  clk_i,
   input wire logic                  rst_i,
   input wire logic                  wb_cyc_i,
   input wire logic                  wb_stb_i,
   input wire logic [31:0]           wb_dat_o,
   input wire logic                  wb_ack_o,
   // video
   input wire logic                  pix_vld_i,
   input wire logic [vk_pkg::PW-1:0] comp_o,
   input wire logic                  comp_vld_o,
   input wire logic [vk_pkg::KW-1:0] key_o
);
   // ************************************************************
   // port relations
   // ************************************************************
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   a_ack_answers: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("no ack one cycle after request");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   a_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
      else $error("read data outside ack");
   a_pix_latency: assert property (pix_vld_i |-> ##2 comp_vld_o)
      else $error("composite not two cycles after pixel");
   a_vld_cause: assert property (comp_vld_o |-> $past(pix_vld_i, 2))
      else $error("composite without pixel");
   a_key_limit: assert property (key_o <= KC_FULL)
      else $error("key beyond opaque");
   a_out_hold: assert property (!comp_vld_o |-> $stable(comp_o) && $stable(key_o))
      else $error("output moved without pixel");
endmodule : vk_monitor
bind vk_keyer vk_monitor u_vk_monitor (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pix_vld_i(pix_vld_i),
   .comp_o(comp_o), .comp_vld_o(comp_vld_o), .key_o(key_o));
`default_nettype wire

//--- verif/vk_src.sv
// upstream video source model
`timescale 1ns/1ps
`default_nettype none
module vk_src
   import vk_pkg::*;
(
   // control
   input  wire logic                    clk_i,
   input  wire logic                    rst_i,
   input  wire logic                    go_i,
   input  wire logic [4*vk_pkg::PW-1:0] px_i,
   // video out
   output logic                         vld_o,
   output logic [vk_pkg::PW-1:0]        bg_o,
   output logic [vk_pkg::PW-1:0]        cut_o,
   output logic [vk_pkg::PW-1:0]        fill_o,
   output logic [vk_pkg::PW-1:0]        pat_o
);
   // ************************************************************
   // pixel launch
   // ************************************************************
   always_ff @(posedge clk_i)
   begin
      vld_o <= go_i && !rst_i;
      if (go_i)
      begin
         {bg_o, cut_o, fill_o, pat_o} <= px_i;
      end
      else if (rst_i)
      begin
         {bg_o, cut_o, fill_o, pat_o} <= '0;
      end
      else
      begin
         // idle lines wander so a stale pixel never passes for a fresh one
         {bg_o, cut_o, fill_o, pat_o} <= ~{bg_o, cut_o, fill_o, pat_o};
      end
   end
endmodule : vk_src
`default_nettype wire

//--- verif/tb.sv
// self-checking bench for the keyer
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_count++; \
   $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb;
   import vk_pkg::*;
   // ************************************************************
   // signals and instances
   // ************************************************************
   logic          clk_i  = 1'b0;
   logic          rst_i  = 1'b1;
   logic          wb_cyc = 1'b0;
   logic          wb_stb = 1'b0;
   logic          wb_we  = 1'b0;
   logic [7:0]    wb_adr = 8'h00;
   logic [31:0]   wb_dat = 32'h0000_0000;
   logic [31:0]   wb_q;
   logic          wb_ack;
   logic          go     = 1'b0;
   logic [39:0]   px_d   = 40'h00_0000_0000;
   logic          pv;
   logic          cvld;
   logic [PW-1:0] pb, pc, pf, pp, comp;
   logic [KW-1:0] key;
   int            err_count = 0;
   int            tests_run = 0;
   vk_src u_vk_src (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .px_i(px_d), .vld_o(pv),
      .bg_o(pb), .cut_o(pc), .fill_o(pf), .pat_o(pp));
   vk_keyer u_vk_keyer (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
      .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_dat),
      .wb_dat_o(wb_q), .wb_ack_o(wb_ack), .pix_vld_i(pv), .bg_i(pb), .cut_i(pc),
      .fill_i(pf), .pat_i(pp), .comp_o(comp), .comp_vld_o(cvld), .key_o(key));
   initial
   begin
      forever #5 clk_i = ~clk_i;
   end
   // ************************************************************
   // bus and pixel tasks
   // ************************************************************
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
      int n = 0;
      @(posedge clk_i);
      {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat} <= {2'b11, we, a, d};
      do
         @(posedge clk_i);
      while (wb_ack !== 1'b1 && n++ < 50);
      if (wb_ack !== 1'b1)
      begin
         err_count++;
         $display("[FAIL] %0t bus request never acknowledged", $time);
      end
      q = wb_q;
      {wb_cyc, wb_stb} <= 2'b00;
   endtask : wb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      wb(1'b0, a, 32'h0000_0000, q);
      `CHK(q, e)
   endtask : rd
   task automatic idle_div;
      logic [31:0] q;
      int n = 0;
      do
         wb(1'b0, ADR_STAT, 32'h0000_0000, q);
      while (q[ST_BUSY_BIT] !== 1'b0 && n++ < 40);
      `CHK(q[ST_BUSY_BIT], 1'b0)
   endtask : idle_div
   task automatic px(input logic [PW-1:0] b, c, f, p, ec, input logic [KW-1:0] ek);
      int n = 0;
      @(posedge clk_i);
      go <= 1'b1;
      px_d <= {b, c, f, p};
      @(posedge clk_i);
      go <= 1'b0;
      do
         @(posedge clk_i);
      while (cvld !== 1'b1 && n++ < 20);
      `CHK(cvld, 1'b1)
      `CHK(comp, ec)
      `CHK(key, ek)
   endtask : px
   // additive adds fill whole, other types weight it by the key
   function automatic logic [PW-1:0] mix(input int t, b, f, k);
      int v;
      v = (t == 0) ? ((b * (1024 - k)) >> 10) + f : (b * (1024 - k) + f * k) >> 10;
      return (v > 1023) ? PIX_MAX : v[PW-1:0];
   endfunction : mix
   // ************************************************************
   // scenarios
   // ************************************************************
   task automatic t_reset;
      rd(ADR_CTRL, 32'h0000_0001);
      rd(ADR_GAIN, 32'h0000_0064);
      rd(ADR_UPPER, 32'h0000_03FF);
      rd(ADR_LOWER, 32'h0000_0001);
      wr(8'h1C, 32'hFFFF_FFFF);
      rd(8'h1C, 32'h0000_0000);
      wr(ADR_STAT, 32'hFFFF_FFFF);
      rd(ADR_STAT, 32'h0000_0000);
   endtask : t_reset
   task automatic t_types;
      logic [PW-1:0] c;
      logic [KW-1:0] k;
      for (int t = 0; t < 5; t++)
      begin
         wr(ADR_CTRL, 32'(t));
         for (int i = 0; i < 3; i++)
         begin
            c = (i == 0) ? 10'h000 : (i == 1) ? 10'h201 : PIX_MAX;
            k = (i == 0) ? 11'h000 : (i == 1) ? 11'h200 : KC_FULL;
            px(10'h100, (t == 4) ? ~c : c, 10'h300, c, mix(t, 256, 768, k), k);
         end
      end
   endtask : t_types
   task automatic t_fill;
      wr(ADR_MATTE, 32'h0000_0155);
      wr(ADR_CTRL, 32'h0000_0031);
      px(10'h100, 10'h000, 10'h3FF, 10'h000, 10'h155, KC_FULL);
      px(10'h100, 10'h3FF, 10'h000, 10'h3FF, 10'h100, 11'h000);
      wr(ADR_CTRL, 32'h0000_0001);
   endtask : t_fill
   task automatic t_gain;
      wr(ADR_GAIN, 32'h0000_0032);
      rd(ADR_UPPER, 32'h0000_02FF);
      rd(ADR_LOWER, 32'h0000_0101);
      wr(ADR_CLIP, 32'h0000_0180);
      rd(ADR_GAIN, 32'h0000_0032);
      rd(ADR_UPPER, 32'h0000_027F);
      wr(ADR_GAIN, 32'h0000_0000);
      rd(ADR_LOWER, 32'h0000_0180);
      px(10'h100, 10'h180, 10'h300, 10'h000, 10'h300, KC_FULL);
      px(10'h100, 10'h17F, 10'h300, 10'h000, 10'h100, 11'h000);
      wr(ADR_CLIP, 32'h0000_0200);
      wr(ADR_GAIN, 32'h0000_00C8);
      rd(ADR_UPPER, 32'h0000_05FF);
      rd(ADR_LOWER, 32'hFFFF_FE01);
      idle_div;
      px(10'h100, 10'h3FF, 10'h300, 10'h000, mix(1, 256, 768, 767), 11'h2FF);
   endtask : t_gain
   task automatic t_thresh;
      wr(ADR_LOWER, 32'h0000_0001);
      rd(ADR_UPPER, 32'h0000_05FF);
      rd(ADR_CLIP, 32'h0000_0300);
      rd(ADR_GAIN, 32'h0000_0096);
      wr(ADR_UPPER, 32'h0000_0301);
      rd(ADR_LOWER, 32'h0000_0001);
      rd(ADR_CLIP, 32'h0000_0181);
      rd(ADR_GAIN, 32'h0000_004B);
      idle_div;
      px(10'h100, 10'h301, 10'h300, 10'h000, 10'h300, KC_FULL);
      px(10'h100, 10'h001, 10'h300, 10'h000, 10'h100, 11'h000);
      px(10'h100, 10'h181, 10'h300, 10'h000, mix(1, 256, 768, 511), 11'h1FF);
   endtask : t_thresh
   task automatic final_report;
      $display("checks %0d errors %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
      begin
         $display("verification passed");
      end
      else
      begin
         $display("verification failed");
      end
      $finish;
   endtask : final_report
   initial
   begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_reset();
      t_types();
      t_fill();
      t_gain();
      t_thresh();
      final_report();
   end
   // the whole run needs well under 2000 cycles
   initial
   begin
      #200000;
      err_count++;
      $display("[FAIL] %0t watchdog expired", $time);
      final_report();
   end
endmodule : tb
`default_nettype wire
